// ### rtl/panel_defines.vh
`ifndef PANEL_DEFINES_VH
`define PANEL_DEFINES_VH
// ==========================================================
// register map (APB byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_TEMP 12'h008
`define REG_PRES 12'h00C
`define REG_ADF 12'h010
`define REG_GAIN0 12'h020
// ==========================================================
// ctrl register fields
`define CTRL_BIAS_OK 0
`define CTRL_SELFTEST_OK 1
// ==========================================================
// screen codes
`define SCR_OFF 4'h0
`define SCR_PIXEL 4'h1
`define SCR_DIAG1 4'h2
`define SCR_DIAG2 4'h3
`define SCR_DIAG3 4'h4
`define SCR_UNITS 4'h5
`define SCR_AIR 4'h6
`define SCR_GAIN 4'h7
`define SCR_MEAS 4'h8
// ==========================================================
// key indices
`define KEY_POWER 0
`define KEY_INFO 1
`define KEY_UNITS 2
`define KEY_AIR 3
`define KEY_GAIN 4
`define KEY_MEAS 5
`define KEY_RESET 6
`define KEY_UP 7
`define KEY_DOWN 8
`define NUM_KEYS 9
// ==========================================================
// timing
`define CLK_HZ 40000000
`define SCREEN_HOLD_MS 2000
`define GAIN_HOLD_MS 3000
`define DEBOUNCE_MS 10
// reset values
`define TEMP_RESET 16'h0016
`define PRES_RESET 16'h03F5
`define ADF_RESET 16'h03E8
`define GAIN_RESET 16'h03E8
`endif

// ### rtl/key_debounce.v
`timescale 1ns/1ps
`include "panel_defines.vh"
// ==========================================================
// key debouncer: two-flop sync then stable-count filter
module key_debounce #(
   parameter CNT_MAX = 400000
) (
   input wire clk,
   input wire rstn,
   input wire key_raw,
   output reg key_level,
   output reg press_pulse,
   output reg release_pulse
);
   reg sync1_q; // first sync stage, read only by sync2_q
   reg sync2_q; // synchronised key
   reg [31:0] cnt_q; // stability counter
   // ==========================================================
   // synchroniser and filter; a level must hold CNT_MAX cycles
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         cnt_q <= 32'h00000000;
         key_level <= 1'b0;
         press_pulse <= 1'b0;
         release_pulse <= 1'b0;
      end else begin
         sync1_q <= key_raw;
         sync2_q <= sync1_q;
         press_pulse <= 1'b0;
         release_pulse <= 1'b0;
         if (sync2_q == key_level) begin
            cnt_q <= 32'h00000000; // no change pending
         end else if (cnt_q >= CNT_MAX - 1) begin
            cnt_q <= 32'h00000000;
            key_level <= sync2_q;
            press_pulse <= sync2_q;
            release_pulse <= ~sync2_q;
         end else begin
            cnt_q <= cnt_q + 32'h00000001;
         end
      end
   end
endmodule

// ### rtl/front_panel_key_sequencer.v
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "panel_defines.vh"
module front_panel_key_sequencer #(
   parameter NUM_CH = 5,
   parameter HOLD_CYCLES = (`CLK_HZ / 1000) * `SCREEN_HOLD_MS,
   parameter GAIN_CYCLES = (`CLK_HZ / 1000) * `GAIN_HOLD_MS,
   parameter DEB_CYCLES = (`CLK_HZ / 1000) * `DEBOUNCE_MS
) (
   input wire clk,
   input wire rstn,
   input wire [`NUM_KEYS-1:0] keys_raw,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg [3:0] screen_q,
   output reg power_on_q,
   output reg rate_units_q,
   output reg percent_mode_q,
   output reg gain_mode_q,
   output reg air_density_enable_q,
   output reg panel_gain_enable_flag_q,
   output reg [1:0] air_cursor_q,
   output reg [2:0] gain_cursor_q,
   output reg clear_readings_q,
   output reg save_q
);
   // ==========================================================
   // declarations
   localparam PU_IDLE = 3'h0; // off
   localparam PU_TEST = 3'h1; // self-test, wait for ok
   localparam PU_PIX = 3'h2; // pixel test screen
   localparam PU_INFO = 3'h3; // general information screen
   localparam PU_BIAS = 3'h4; // waiting for bias supply
   localparam PU_RUN = 3'h5; // operational
   reg [2:0] pu_q; // power-up sequence state
   reg [31:0] tmr_q; // screen hold timer
   reg [31:0] gain_tmr_q; // gain key hold timer
   reg gain_long_q; // long hold already acted on
   reg [3:0] diag_prev_q; // screen shown before the info key entered a diag screen
   reg [1:0] ctrl_q; // software status inputs: bias ok, self-test ok
   reg [15:0] temp_q; // live temperature
   reg [15:0] pres_q; // live pressure
   reg [15:0] adf_q; // air_density_factor
   reg [15:0] gain_q [0:NUM_CH-1]; // panel_gain_factor per chamber
   reg [15:0] s_temp_q; // retained copies
   reg [15:0] s_pres_q;
   reg [15:0] s_adf_q;
   reg s_rate_q;
   reg [15:0] s_gain_q [0:NUM_CH-1];
   wire [`NUM_KEYS-1:0] lvl; // debounced levels
   wire [`NUM_KEYS-1:0] prs; // debounced press pulses
   wire [`NUM_KEYS-1:0] rel; // debounced release pulses
   wire run = (pu_q == PU_RUN); // keys accepted
   wire on_diag = (screen_q == `SCR_DIAG1) || (screen_q == `SCR_DIAG2) || (screen_q == `SCR_DIAG3);
   wire nav_scr = on_diag || (screen_q == `SCR_MEAS);
   wire wr = psel && penable && pwrite;
   integer i;
   // ==========================================================
   // one debouncer per key
   genvar g;
   generate
      for (g = 0; g < `NUM_KEYS; g = g + 1) begin : g_deb
         key_debounce #(.CNT_MAX(DEB_CYCLES)) u_deb (
            .clk(clk),
            .rstn(rstn),
            .key_raw(keys_raw[g]),
            .key_level(lvl[g]),
            .press_pulse(prs[g]),
            .release_pulse(rel[g])
         );
      end
   endgenerate
   // ==========================================================
   // apb: zero wait state, no error
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // read mux; unmapped reads return zero
   always @* begin
      prdata = 32'h00000000;
      case (paddr)
         `REG_CTRL: prdata = {30'h00000000, ctrl_q};
         `REG_STATUS: prdata = {12'h000, gain_cursor_q, air_cursor_q, clear_readings_q, save_q,
            panel_gain_enable_flag_q, air_density_enable_q, gain_mode_q, percent_mode_q, rate_units_q,
            power_on_q, pu_q, screen_q};
         `REG_TEMP: prdata = {16'h0000, temp_q};
         `REG_PRES: prdata = {16'h0000, pres_q};
         `REG_ADF: prdata = {16'h0000, adf_q};
         default: begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
               if (paddr == `REG_GAIN0 + i * 4) prdata = {16'h0000, gain_q[i]};
            end
         end
      endcase
   end
   // ==========================================================
   // gain key hold timer; long hold acts once while held
   wire gain_long = run && lvl[`KEY_GAIN] && !gain_long_q && (gain_tmr_q >= GAIN_CYCLES - 1);
   wire gain_short = run && rel[`KEY_GAIN] && !gain_long_q;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gain_tmr_q <= 32'h00000000;
         gain_long_q <= 1'b0;
      end else if (!lvl[`KEY_GAIN]) begin
         gain_tmr_q <= 32'h00000000;
         if (rel[`KEY_GAIN] || !gain_long_q) gain_long_q <= 1'b0;
      end else begin
         if (gain_tmr_q < GAIN_CYCLES) gain_tmr_q <= gain_tmr_q + 32'h00000001;
         if (gain_long) gain_long_q <= 1'b1;
      end
   end
   // ==========================================================
   // main sequencer: power, screens, settings
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pu_q <= PU_IDLE;
         tmr_q <= 32'h00000000;
         screen_q <= `SCR_OFF;
         diag_prev_q <= `SCR_MEAS;
         power_on_q <= 1'b0;
         rate_units_q <= 1'b0;
         percent_mode_q <= 1'b0;
         gain_mode_q <= 1'b0;
         air_density_enable_q <= 1'b1;
         panel_gain_enable_flag_q <= 1'b1;
         air_cursor_q <= 2'h0;
         gain_cursor_q <= 3'h0;
         clear_readings_q <= 1'b0;
         save_q <= 1'b0;
         ctrl_q <= 2'h0;
         temp_q <= `TEMP_RESET;
         pres_q <= `PRES_RESET;
         adf_q <= `ADF_RESET;
         s_temp_q <= `TEMP_RESET;
         s_pres_q <= `PRES_RESET;
         s_adf_q <= `ADF_RESET;
         s_rate_q <= 1'b0;
         for (i = 0; i < NUM_CH; i = i + 1) begin
            gain_q[i] <= `GAIN_RESET;
            s_gain_q[i] <= `GAIN_RESET;
         end
      end else begin
         clear_readings_q <= 1'b0;
         save_q <= 1'b0;
         if (wr && paddr == `REG_CTRL) ctrl_q <= pwdata[1:0];
         // power key is honoured at any time so the unit can always be turned off
         if (prs[`KEY_POWER]) begin
            if (power_on_q) begin
               power_on_q <= 1'b0;
               pu_q <= PU_IDLE;
               screen_q <= `SCR_OFF;
               gain_mode_q <= 1'b0;
               save_q <= 1'b1;
               s_temp_q <= temp_q;
               s_pres_q <= pres_q;
               s_adf_q <= adf_q;
               s_rate_q <= rate_units_q;
               for (i = 0; i < NUM_CH; i = i + 1) s_gain_q[i] <= gain_q[i];
            end else begin
               power_on_q <= 1'b1;
               pu_q <= PU_TEST;
            end
         end else begin
            case (pu_q)
               PU_IDLE: begin
                  tmr_q <= 32'h00000000;
               end
               PU_TEST: begin
                  if (ctrl_q[`CTRL_SELFTEST_OK]) begin
                     temp_q <= s_temp_q;
                     pres_q <= s_pres_q;
                     adf_q <= s_adf_q;
                     rate_units_q <= s_rate_q;
                     for (i = 0; i < NUM_CH; i = i + 1) gain_q[i] <= s_gain_q[i];
                     screen_q <= `SCR_PIXEL;
                     tmr_q <= 32'h00000000;
                     pu_q <= PU_PIX;
                  end
               end
               PU_PIX: begin
                  if (tmr_q >= HOLD_CYCLES - 1) begin
                     tmr_q <= 32'h00000000;
                     screen_q <= `SCR_DIAG1;
                     pu_q <= PU_INFO;
                  end else tmr_q <= tmr_q + 32'h00000001;
               end
               PU_INFO: begin
                  if (tmr_q >= HOLD_CYCLES - 1) begin
                     tmr_q <= 32'h00000000;
                     pu_q <= PU_BIAS;
                  end else tmr_q <= tmr_q + 32'h00000001;
               end
               PU_BIAS: begin
                  // bias screen only once supply settles; keys other than power stay locked till then
                  if (ctrl_q[`CTRL_BIAS_OK]) begin
                     screen_q <= `SCR_DIAG3;
                     pu_q <= PU_RUN;
                  end
               end
               PU_RUN: begin
                  if (gain_long) begin
                     gain_mode_q <= ~gain_mode_q;
                     screen_q <= `SCR_GAIN;
                     gain_cursor_q <= 3'h0;
                  end else if (gain_short) begin
                     if (screen_q != `SCR_GAIN) screen_q <= `SCR_GAIN;
                     else if (gain_mode_q) begin
                        // cursor 0 is the flag, 1..NUM_CH the chambers
                        if (gain_cursor_q >= NUM_CH) gain_cursor_q <= 3'h0;
                        else gain_cursor_q <= gain_cursor_q + 3'h1;
                     end
                  end else if (prs[`KEY_INFO]) begin
                     if (!on_diag) begin
                        diag_prev_q <= screen_q;
                        screen_q <= `SCR_DIAG1;
                     end else if (screen_q == `SCR_DIAG3) screen_q <= `SCR_DIAG1;
                     else screen_q <= screen_q + 4'h1;
                  end else if (prs[`KEY_UNITS]) begin
                     if (screen_q == `SCR_UNITS) rate_units_q <= ~rate_units_q;
                     else screen_q <= `SCR_UNITS;
                  end else if (prs[`KEY_AIR]) begin
                     if (screen_q != `SCR_AIR) begin
                        screen_q <= `SCR_AIR;
                        air_cursor_q <= 2'h0;
                     end else if (air_cursor_q == 2'h2) air_cursor_q <= 2'h0;
                     else air_cursor_q <= air_cursor_q + 2'h1;
                  end else if (prs[`KEY_MEAS]) begin
                     if (screen_q == `SCR_MEAS) percent_mode_q <= ~percent_mode_q;
                     else screen_q <= `SCR_MEAS;
                  end else if (prs[`KEY_RESET]) begin
                     if (!rate_units_q) clear_readings_q <= 1'b1;
                     if (screen_q != `SCR_MEAS) screen_q <= `SCR_MEAS;
                  end else if (prs[`KEY_UP] || prs[`KEY_DOWN]) begin
                     if (screen_q == `SCR_AIR) begin
                        // air cursor: 0 temp, 1 pressure, 2 correction flag
                        if (air_cursor_q == 2'h2) air_density_enable_q <= ~air_density_enable_q;
                        else if (air_cursor_q == 2'h0) begin
                           if (prs[`KEY_UP]) temp_q <= temp_q + 16'h0001;
                           else temp_q <= temp_q - 16'h0001;
                        end else begin
                           if (prs[`KEY_UP]) pres_q <= pres_q + 16'h0001;
                           else pres_q <= pres_q - 16'h0001;
                        end
                     end else if (screen_q == `SCR_GAIN) begin
                        if (gain_cursor_q == 3'h0) panel_gain_enable_flag_q <= ~panel_gain_enable_flag_q;
                        else if (gain_mode_q) begin
                           for (i = 0; i < NUM_CH; i = i + 1) begin
                              if (gain_cursor_q == i + 1) begin
                                 if (prs[`KEY_UP]) gain_q[i] <= gain_q[i] + 16'h0001;
                                 else gain_q[i] <= gain_q[i] - 16'h0001;
                              end
                           end
                        end
                     end else if (nav_scr) begin
                        if (prs[`KEY_UP]) begin
                           if (screen_q == `SCR_DIAG1) screen_q <= `SCR_MEAS;
                           else if (screen_q == `SCR_MEAS) screen_q <= `SCR_DIAG3;
                           else screen_q <= screen_q - 4'h1;
                        end else begin
                           if (screen_q == `SCR_MEAS) screen_q <= `SCR_DIAG1;
                           else if (screen_q == `SCR_DIAG3) screen_q <= `SCR_MEAS;
                           else screen_q <= screen_q + 4'h1;
                        end
                     end
                  end
               end
               default: pu_q <= PU_IDLE;
            endcase
         end
      end
   end
endmodule

// ### bench/fpks_chk.sv
`timescale 1ns/1ps
`include "panel_defines.vh"
// ==========================================================
// checker: port relations of the panel sequencer
module fpks_chk #(
   parameter HOLD_CYCLES = 20,
   parameter NUM_CH = 5
) (
   input wire clk,
   input wire rstn,
   input wire [3:0] screen_q,
   input wire power_on_q,
   input wire rate_units_q,
   input wire percent_mode_q,
   input wire [1:0] air_cursor_q,
   input wire [2:0] gain_cursor_q,
   input wire clear_readings_q,
   input wire save_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [31:0] pix_q; // cycles spent on the pixel screen
   // ==========================================================
   // pixel dwell counter, cleared on any other screen
   always @(posedge clk or negedge rstn) begin
      if (!rstn) pix_q <= '0;
      else pix_q <= (screen_q == `SCR_PIXEL) ? pix_q + 1 : '0;
   end
   // pixel screen hands over to the general info screen
   sequence s_pixel_done;
      $past(screen_q) == `SCR_PIXEL && screen_q == `SCR_DIAG1;
   endsequence
   // a running unit before and after the edge, on a live screen before it
   sequence s_live;
      $past(power_on_q) && power_on_q && $past(screen_q) != `SCR_OFF && $past(screen_q) != `SCR_PIXEL;
   endsequence
   // ==========================================================
   // assertions; a small slack allows for the state register
   a_pixel_time: assert property (s_pixel_done |-> pix_q >= HOLD_CYCLES - 2 && pix_q <= HOLD_CYCLES + 2)
      else $error("pixel screen dwell wrong");
   a_pixel_exit: assert property (screen_q == `SCR_PIXEL |=> screen_q inside {`SCR_PIXEL, `SCR_DIAG1, `SCR_OFF})
      else $error("key acted during power-up");
   a_save_off: assert property (save_q |-> ##[0:3] !power_on_q)
      else $error("save pulse without power-off");
   a_clear_dose: assert property (clear_readings_q |-> !rate_units_q)
      else $error("readings cleared in rate units");
   a_clear_meas: assert property (clear_readings_q |-> ##[0:2] screen_q == `SCR_MEAS)
      else $error("reset key did not show measurement");
   a_pulse_single: assert property ((clear_readings_q || save_q) |=> !(clear_readings_q || save_q))
      else $error("pulse longer than one cycle");
   a_units_where: assert property ((s_live and $changed(rate_units_q)) |-> $past(screen_q) == `SCR_UNITS)
      else $error("units changed off units screen");
   a_pct_where: assert property ((s_live and $changed(percent_mode_q)) |-> $past(screen_q) == `SCR_MEAS)
      else $error("presentation changed off measure screen");
   a_cursor_range: assert property (air_cursor_q != 2'h3 && gain_cursor_q <= NUM_CH)
      else $error("cursor out of range");
   a_off_dark: assert property ($fell(power_on_q) |-> ##[0:2] screen_q == `SCR_OFF)
      else $error("screen not dark after power-off");
endmodule
bind front_panel_key_sequencer fpks_chk #(.HOLD_CYCLES(HOLD_CYCLES), .NUM_CH(NUM_CH)) chk_u (.clk(clk), .rstn(rstn),
   .screen_q(screen_q), .power_on_q(power_on_q), .rate_units_q(rate_units_q), .percent_mode_q(percent_mode_q),
   .air_cursor_q(air_cursor_q), .gain_cursor_q(gain_cursor_q), .clear_readings_q(clear_readings_q), .save_q(save_q));

// ### bench/key_operator.sv
`timescale 1ns/1ps
// ==========================================================
// operator model: one press with contact chatter, hold, release gap
module key_operator (
   input wire logic clk,
   input wire logic go,
   input wire logic [3:0] key,
   input wire logic [7:0] hold,
   output logic [8:0] keys_raw,
   output logic busy
);
   logic [8:0] e_q; // cycles since the press began
   logic [3:0] key_q; // key being pressed
   logic [8:0] hold_q; // cycles held after chatter
   initial begin
      keys_raw = '0;
      busy = 1'b0;
      e_q = '0;
   end
   // chatter: on one cycle, off one, then held; released keys read low
   always @(posedge clk) begin
      if (!busy) begin
         busy <= go;
         key_q <= key;
         hold_q <= {1'b0, hold};
         e_q <= 9'h001;
         keys_raw <= go ? (9'h001 << key) : 9'h000;
      end else begin
         e_q <= e_q + 9'h001;
         keys_raw <= (e_q >= 2 && e_q < hold_q + 2) ? (9'h001 << key_q) : 9'h000;
         busy <= (e_q < hold_q + 14); // gap lets the release settle
      end
   end
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "panel_defines.vh"
module tb_top;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rd, t0;
   logic [3:0] key = '0;
   logic [7:0] hold = '0;
   logic exp_fl;
   wire [8:0] keys_raw;
   wire [31:0] prdata;
   wire [3:0] screen_q;
   wire [1:0] air_c;
   wire [2:0] gain_c;
   wire pready, pslverr, busy, power_on_q, rate_q, pct_q, gmode_q, adf_q, pgf_q, clr_q, save_q;
   int n_mismatch = 0, checks_done = 0, cyc = 0, n_clr = 0, n_save = 0, n;
   int nav_k[9] = '{`KEY_INFO, `KEY_INFO, `KEY_INFO, `KEY_INFO, `KEY_DOWN, `KEY_DOWN, `KEY_DOWN, `KEY_UP, `KEY_UP};
   int nav_s[9] = '{`SCR_DIAG1, `SCR_DIAG2, `SCR_DIAG3, `SCR_DIAG1, `SCR_DIAG2, `SCR_DIAG3, `SCR_MEAS, `SCR_DIAG3,
      `SCR_DIAG2};
   always #12.5 clk = ~clk;
   key_operator op_u (.clk(clk), .go(go), .key(key), .hold(hold), .keys_raw(keys_raw), .busy(busy));
   // short counts keep the run brief
   front_panel_key_sequencer #(.HOLD_CYCLES(20), .GAIN_CYCLES(30), .DEB_CYCLES(4)) dut_u (.clk(clk), .rstn(rstn),
      .keys_raw(keys_raw), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .screen_q(screen_q), .power_on_q(power_on_q),
      .rate_units_q(rate_q), .percent_mode_q(pct_q), .gain_mode_q(gmode_q), .air_density_enable_q(adf_q),
      .panel_gain_enable_flag_q(pgf_q), .air_cursor_q(air_c), .gain_cursor_q(gain_c), .clear_readings_q(clr_q),
      .save_q(save_q));
   // ==========================================================
   // pulse counters and hang guard
   always @(posedge clk) begin
      n_clr += (clr_q === 1'b1);
      n_save += (save_q === 1'b1);
      if (++cyc > 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ==========================================================
   // compare tasks
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task chk_gt(input string what, input logic [31:0] lo, input logic [31:0] got);
      checks_done++;
      if ((got > lo) !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %s expected above %h seen %h", what, lo, got);
      end
   endtask
   // apb transfer; entered just after a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   // one operator press, then let debounce settle
   task press(input logic [3:0] k, input logic [7:0] h = 8'h0A);
      key <= k;
      hold <= h;
      go <= 1;
      @(posedge clk) go <= 0;
      do @(posedge clk); while (busy);
      repeat (4) @(posedge clk);
   endtask
   task powerup;
      apb(1, `REG_CTRL, 0);
      press(`KEY_POWER);
      chk("power on", 1, power_on_q);
      apb(1, `REG_CTRL, 2);
      press(`KEY_UNITS);
      chk("screen locked", `SCR_DIAG1, screen_q);
      repeat (25) @(posedge clk);
      chk("await bias", `SCR_DIAG1, screen_q);
      apb(1, `REG_CTRL, 3);
      repeat (2) @(posedge clk);
      chk("bias screen", `SCR_DIAG3, screen_q);
   endtask
   function automatic logic [1:0] next_air(input logic [1:0] c);
      return (c == 2'h2) ? 2'h0 : c + 2'h1;
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rd = $urandom(32'hCF4471F2);
      repeat (10) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      chk("flags at reset", 3'h7, {screen_q == `SCR_OFF, adf_q, pgf_q});
      press(`KEY_INFO);
      chk("off ignores keys", `SCR_OFF, screen_q);
      apb(1, 12'h0FC, 32'hFFFFFFFF);
      apb(0, 12'h0FC, 0);
      chk("unmapped", 0, rd);
      powerup();
      apb(0, `REG_TEMP, 0);
      chk("temp restored", `TEMP_RESET, rd);
      for (int i = 0; i < 9; i++) begin
         press(nav_k[i]);
         chk("nav screen", nav_s[i], screen_q);
      end
      press(`KEY_UNITS);
      chk("units shown", {4'(`SCR_UNITS), 1'b0}, {screen_q, rate_q});
      press(`KEY_UNITS);
      chk("rate units", 1, rate_q);
      n = n_clr;
      press(`KEY_RESET);
      chk("no clear in rate", {n, 4'(`SCR_MEAS)}, {n_clr, screen_q});
      press(`KEY_UNITS);
      press(`KEY_UNITS);
      press(`KEY_RESET);
      chk("clear in dose", {n + 1, 4'(`SCR_MEAS)}, {n_clr, screen_q});
      press(`KEY_MEAS);
      chk("percent", 1, pct_q);
      press(`KEY_MEAS);
      chk("absolute", 0, pct_q);
      press(`KEY_AIR);
      chk("air screen", `SCR_AIR, screen_q);
      repeat (3) begin
         exp_fl = 0;
         t0 = next_air(air_c);
         press(`KEY_AIR);
         chk("air cursor", t0, air_c);
      end
      while (air_c !== 2'h2 && cyc < 19000) press(`KEY_AIR);
      exp_fl = adf_q;
      n = $urandom_range(1, 5);
      repeat (n) press($urandom_range(0, 1) ? `KEY_UP : `KEY_DOWN);
      chk("air flag", exp_fl ^ n[0], adf_q);
      press(`KEY_AIR);
      apb(0, `REG_TEMP, 0);
      t0 = rd;
      press(`KEY_UP);
      apb(0, `REG_TEMP, 0);
      chk_gt("temp up", t0, rd);
      press(`KEY_DOWN);
      apb(0, `REG_TEMP, 0);
      chk("temp down", t0, rd);
      press(`KEY_UP);
      apb(0, `REG_TEMP, 0);
      t0 = rd;
      press(`KEY_GAIN, 8'd60);
      chk("gain mode", {4'(`SCR_GAIN), 1'b1}, {screen_q, gmode_q});
      press(`KEY_UP);
      chk("gain flag", 0, pgf_q);
      n = gain_c;
      press(`KEY_GAIN);
      chk("gain cursor", {3'(n + 1), 1'b1}, {gain_c, gmode_q});
      apb(0, `REG_GAIN0, 0);
      exp_fl = 0;
      rd = rd;
      n = rd;
      press(`KEY_UP);
      apb(0, `REG_GAIN0, 0);
      chk_gt("gain up", n, rd);
      press(`KEY_DOWN);
      apb(0, `REG_GAIN0, 0);
      chk("gain down", n, rd);
      press(`KEY_GAIN, 8'd60);
      chk("normal mode", 0, gmode_q);
      n = n_save;
      press(`KEY_POWER);
      chk("power off", {n + 1, 1'b0}, {n_save, power_on_q});
      powerup();
      apb(0, `REG_TEMP, 0);
      chk("temp retained", t0, rd);
      end_of_test();
   end
endmodule
